// File: rtl/eeprom_cpu_end.sv
/*
 * CPU end of the data EEPROM link: an AXI4-Lite slave whose command
 * register issues register writes to the controller and whose status
 * register shows the controller's control and data registers and interrupt request.
 * Assumes software follows the documented write and fill sequences.
 */
`timescale 1ns/100ps
module eeprom_cpu_end (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         arst_n,
    // register link
    eeprom_sfr_if.cpu                         sfr,
    // AXI4-Lite write channels
    input  wire logic [eeprom_pkg::AXI_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                   awprot,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    // AXI4-Lite read channels
    input  wire logic [eeprom_pkg::AXI_ADDR_W-1:0] araddr,
    input  wire logic [2:0]                   arprot,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready
);
    import eeprom_pkg::*;

    logic                  aw_held;
    logic                  w_held;
    logic [AXI_ADDR_W-1:0] aw_q;
    logic [31:0]           w_q;
    logic [3:0]            ws_q;
    logic                  sfr_wr_q;
    logic [1:0]            sel_q;
    logic [7:0]            wd_q;
    logic                  done_en_q;
    logic                  glob_en_q;

    // ************************************************************
    // decode
    // ************************************************************
    wire aw_take  = awvalid && awready;
    wire w_take   = wvalid && wready;
    wire do_write = aw_held && w_held && !bvalid;
    wire hit_cmd  = (aw_q == OFF_CMD);
    wire hit_ien  = (aw_q == OFF_IRQ_EN);
    wire cmd_ok   = hit_cmd && (ws_q[1:0] == 2'h3);
    wire ien_ok   = hit_ien && ws_q[0];
    wire ar_take  = arvalid && arready;
    wire ar_map   = (araddr == OFF_CMD) || (araddr == OFF_IRQ_EN)
                    || (araddr == OFF_STATUS);
    wire [31:0] status_word = {15'h0000, sfr.irq_req,
                               sfr.data_rdata, sfr.ctrl_rdata};
    wire [31:0] rd_word = (araddr == OFF_IRQ_EN) ? {30'h0, glob_en_q, done_en_q}
                        : (araddr == OFF_STATUS) ? status_word : 32'h0000_0000;

    // ************************************************************
    // write path
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_q    <= '0;
            w_q     <= 32'h0000_0000;
            ws_q    <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                aw_q    <= awaddr;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                wready <= 1'b0;
                w_q    <= wdata;
                ws_q   <= wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (hit_cmd || hit_ien) ? RESP_OKAY : RESP_SLV;
            end
            else if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // one register-link write per accepted command with byte strobes 0 and 1 set; sequencing is software's
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sfr_wr_q  <= 1'b0;
            sel_q     <= SEL_CTRL;
            wd_q      <= 8'h00;
            done_en_q <= 1'b0;
            glob_en_q <= 1'b0;
        end
        else
        begin
            sfr_wr_q <= do_write && cmd_ok;
            if (do_write && cmd_ok)
            begin
                sel_q <= w_q[9:8];
                wd_q  <= w_q[7:0];
            end
            if (do_write && ien_ok)
            begin
                done_en_q <= w_q[0];
                glob_en_q <= w_q[1];
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= ar_map ? RESP_OKAY : RESP_SLV;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    assign sfr.sfr_wr        = sfr_wr_q;
    assign sfr.sfr_sel       = sel_q;
    assign sfr.sfr_wdata     = wd_q;
    assign sfr.done_irq_en   = done_en_q;
    assign sfr.global_irq_en = glob_en_q;

endmodule // eeprom_cpu_end

// File: rtl/eeprom_ctrl.sv
/*
 * Data EEPROM controller: 512-byte array with byte read/write, row fill
 * and block fill, steered by control, data and address registers.
 * Assumes the register writer is synchronous to clk and that the
 * brownout input is already synchronous.
 */
`timescale 1ns/100ps
module eeprom_ctrl #(
    parameter int unsigned OP_CYCLES = eeprom_pkg::OP_CYCLES_DEF
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // register link
    eeprom_sfr_if.dev sfr,
    // supply monitor
    input  wire logic vdd_low,
    // status
    output logic      busy
);
    import eeprom_pkg::*;

    localparam int TW = $clog2(OP_CYCLES + 1);

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG} state_t;

    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0] mem [ARRAY_BYTES];
    state_t     state;
    logic [1:0] op_mode_sel;
    logic       addr_bit_eight;
    logic       op_done_flag;
    logic       blocked_request_flag;
    logic       lowvolt_during_op_flag;
    logic [7:0] eeprom_data_reg;
    logic [7:0] eeprom_addr_reg;
    logic       armed;
    logic [8:0] base_addr;
    logic [9:0] fill_len;
    logic [9:0] fill_idx;
    logic [TW-1:0] timer;
    logic       irq_q;

    // ************************************************************
    // decode
    // ************************************************************
    wire idle       = (state == ST_IDLE);
    wire wr_ctrl    = sfr.sfr_wr && (sfr.sfr_sel == SEL_CTRL);
    wire wr_data    = sfr.sfr_wr && (sfr.sfr_sel == SEL_DATA);
    wire wr_addr    = sfr.sfr_wr && (sfr.sfr_sel == SEL_ADDR);
    wire byte_mode  = (op_mode_sel == MODE_BYTE);
    wire row_mode   = (op_mode_sel == MODE_ROW);
    wire blk_mode   = (op_mode_sel == MODE_BLOCK);
    wire start      = wr_addr && idle;
    wire start_read = start && byte_mode && !armed;
    wire start_prog = start && ((byte_mode && armed) || row_mode || blk_mode);
    wire blocked    = start_prog && vdd_low;
    wire go_prog    = start_prog && !vdd_low;
    wire fill_more  = (state == ST_PROG) && (fill_idx < fill_len);
    wire [8:0] wr_ptr = 9'(base_addr + fill_idx[8:0]);
    // done only once the timer ran out and every byte was written
    wire prog_end   = (state == ST_PROG) && (timer >= TW'(OP_CYCLES - 1))
                      && !fill_more;
    wire read_end   = (state == ST_READ) && (timer == TW'(READ_CYCLES - 1));
    wire [8:0] byte_addr = {addr_bit_eight, sfr.sfr_wdata};
    // software write of zero clears a flag, write of one leaves it
    wire clr_done   = wr_ctrl && !sfr.sfr_wdata[DONE_BIT];
    wire clr_block  = wr_ctrl && !sfr.sfr_wdata[BLOCKED_BIT];
    wire clr_lowv   = wr_ctrl && !sfr.sfr_wdata[LOWV_BIT];

    // operation footprint chosen from the mode at the start
    logic [8:0] next_base;
    logic [9:0] next_len;
    always_comb
    begin
        next_base = byte_addr;
        next_len  = 10'h001;
        if (row_mode)
        begin
            next_base = {addr_bit_eight, sfr.sfr_wdata[7:6], 6'h00};
            next_len  = 10'(ROW_BYTES);
        end
        else if (blk_mode)
        begin
            next_base = 9'h000;
            next_len  = 10'(ARRAY_BYTES);
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_IDLE;
            timer <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    timer <= '0;
                    if (start_read)
                        state <= ST_READ;
                    else if (go_prog)
                        state <= ST_PROG;
                end
                ST_READ:
                begin
                    timer <= TW'(timer + 1'b1);
                    if (read_end)
                        state <= ST_IDLE;
                end
                ST_PROG:
                begin
                    if (timer < TW'(OP_CYCLES - 1))
                        timer <= TW'(timer + 1'b1);
                    if (prog_end)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // operation footprint and fill walker
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            base_addr <= 9'h000;
            fill_len  <= 10'h000;
            fill_idx  <= 10'h000;
        end
        else if (start)
        begin
            base_addr <= next_base;
            fill_len  <= next_len;
            fill_idx  <= 10'h000;
        end
        else if (fill_more)
            fill_idx <= 10'(fill_idx + 1'b1);
    end

    // one byte per clock; a block fill is done long before the timer
    always_ff @(posedge clk)
    begin
        if (fill_more)
            mem[wr_ptr] <= eeprom_data_reg;
    end

    // ************************************************************
    // registers seen by software
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_mode_sel    <= CTRL_RST[MODE_LSB+1:MODE_LSB];
            addr_bit_eight <= CTRL_RST[A8_BIT];
        end
        else if (wr_ctrl)
        begin
            // held until software rewrites them
            op_mode_sel    <= sfr.sfr_wdata[MODE_LSB+1:MODE_LSB];
            addr_bit_eight <= sfr.sfr_wdata[A8_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_done_flag           <= 1'b0;
            blocked_request_flag   <= 1'b0;
            lowvolt_during_op_flag <= 1'b0;
        end
        else
        begin
            // set wins over a clear in the same cycle
            op_done_flag <= prog_end || read_end || (op_done_flag && !clr_done);
            blocked_request_flag <= blocked || (blocked_request_flag && !clr_block);
            lowvolt_during_op_flag <= ((state == ST_PROG) && vdd_low)
                || (lowvolt_during_op_flag && !clr_lowv);
        end
    end

    // data register: loaded by software or by a finished read only
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            eeprom_data_reg <= DATA_RST;
        else if (read_end)
            eeprom_data_reg <= mem[{base_addr[8], eeprom_addr_reg}];
        else if (wr_data && idle)
            eeprom_data_reg <= sfr.sfr_wdata;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            eeprom_addr_reg <= 8'h00;
        else if (start)
            eeprom_addr_reg <= sfr.sfr_wdata;
    end

    // pending write memory
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            armed <= 1'b0;
        else if (start)
            armed <= 1'b0;
        else if (wr_data && idle && byte_mode)
            armed <= 1'b1;
    end

    // ************************************************************
    // interrupt and outputs
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_q <= 1'b0;
            busy  <= 1'b0;
        end
        else
        begin
            irq_q <= op_done_flag && sfr.done_irq_en && sfr.global_irq_en;
            busy  <= !((state == ST_IDLE) ? !(start_read || go_prog) : (prog_end || read_end));
        end
    end

    assign sfr.irq_req    = irq_q;
    assign sfr.data_rdata = eeprom_data_reg;
    // bit 6 and bit 3 read as zero
    assign sfr.ctrl_rdata = {op_done_flag, 1'b0, op_mode_sel, 1'b0,
                             blocked_request_flag, lowvolt_during_op_flag, addr_bit_eight};

endmodule // eeprom_ctrl

// File: rtl/eeprom_pkg.sv
/*
 * Shared constants for the data EEPROM controller and its CPU-side
 * register end. Assumes a single 100 MHz clock for both ends.
 */
package eeprom_pkg;
    // ************************************************************
    // special function register selects
    // ************************************************************
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_DATA = 2'h1;
    localparam logic [1:0] SEL_ADDR = 2'h2;

    // ************************************************************
    // control register layout
    // ************************************************************
    localparam int DONE_BIT    = 7;
    localparam int MODE_LSB    = 4;
    localparam int BLOCKED_BIT = 2;
    localparam int LOWV_BIT    = 1;
    localparam int A8_BIT      = 0;
    localparam logic [1:0] MODE_BYTE  = 2'h0;
    localparam logic [1:0] MODE_ROW   = 2'h2;
    localparam logic [1:0] MODE_BLOCK = 2'h3;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;

    // ************************************************************
    // array geometry and timing
    // ************************************************************
    localparam int ROW_BYTES     = 64;
    localparam int ARRAY_BYTES   = 512;
    localparam int OP_TIME_NS    = 4000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int OP_CYCLES_DEF = OP_TIME_NS / CLK_PERIOD_NS;
    localparam int READ_CYCLES   = 3;

    // ************************************************************
    // AXI4-Lite register map of the CPU end
    // ************************************************************
    localparam int         AXI_ADDR_W = 4;
    localparam logic [3:0] OFF_CMD    = 4'h0;
    localparam logic [3:0] OFF_IRQ_EN = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;
endpackage

// File: rtl/eeprom_sfr_if.sv
/*
 * Special function register link between the CPU end and the data
 * EEPROM controller. Both ends run on the same clock.
 */
`timescale 1ns/100ps
interface eeprom_sfr_if;
    logic       sfr_wr;
    logic [1:0] sfr_sel;
    logic [7:0] sfr_wdata;
    logic [7:0] ctrl_rdata;
    logic [7:0] data_rdata;
    logic       irq_req;
    logic       done_irq_en;
    logic       global_irq_en;

    modport dev (
        input  sfr_wr,
        input  sfr_sel,
        input  sfr_wdata,
        input  done_irq_en,
        input  global_irq_en,
        output ctrl_rdata,
        output data_rdata,
        output irq_req
    );

    modport cpu (
        output sfr_wr,
        output sfr_sel,
        output sfr_wdata,
        output done_irq_en,
        output global_irq_en,
        input  ctrl_rdata,
        input  data_rdata,
        input  irq_req
    );
endinterface // eeprom_sfr_if

// File: testbench/eeprom_link_props.sv
/*
 * Assertions on the register link between the CPU end and the EEPROM controller.
 * Assumes every signal shares clk and arst_n.
 */
`timescale 1ns/100ps
module eeprom_link_props #(
    parameter int unsigned OP_CYCLES = eeprom_pkg::OP_CYCLES_DEF
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // register link
    input  wire logic       sfr_wr,
    input  wire logic [1:0] sfr_sel,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic [7:0] ctrl_rdata,
    input  wire logic [7:0] data_rdata,
    input  wire logic       irq_req,
    input  wire logic       done_irq_en,
    input  wire logic       global_irq_en
);
    import eeprom_pkg::*;
    // ****************
    // helper state
    // ****************
    logic        armed;
    logic        wr_act;
    logic [31:0] wr_cnt;
    wire  [1:0]  mode    = ctrl_rdata[MODE_LSB+1:MODE_LSB];
    wire         done    = ctrl_rdata[DONE_BIT];
    wire         addr_wr = sfr_wr && sfr_sel == SEL_ADDR;
    wire         ctrl_wr = sfr_wr && sfr_sel == SEL_CTRL;
    wire         read_st = addr_wr && mode == MODE_BYTE && !armed;
    wire         prog_st = addr_wr && (mode[1] || (mode == MODE_BYTE && armed));

    // the bench never writes while busy, so the shadow ignores that case
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            armed <= 1'b0;
        else if (addr_wr)
            armed <= 1'b0;
        else if (sfr_wr && sfr_sel == SEL_DATA && mode == MODE_BYTE)
            armed <= 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_act <= 1'b0;
            wr_cnt <= '0;
        end
        else if (prog_st)
        begin
            wr_act <= 1'b1;
            wr_cnt <= '0;
        end
        else
        begin
            wr_act <= wr_act && !done && !ctrl_rdata[BLOCKED_BIT];
            wr_cnt <= wr_cnt + 32'h1;
        end
    end

    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_irq_on: assert property (done && done_irq_en && global_irq_en |=> irq_req)
        else $error("irq missing");
    a_irq_off: assert property (!(done_irq_en && global_irq_en) |=> !irq_req)
        else $error("irq without enables");
    a_done_sticky: assert property (done && !(ctrl_wr && !sfr_wdata[DONE_BIT]) |=> done)
        else $error("done dropped");
    a_read_lat: assert property (read_st && !done |=> !done ##[2:3] done)
        else $error("read latency");
    a_op_time: assert property ($rose(done) && wr_act |-> wr_cnt >= OP_CYCLES
        && wr_cnt <= OP_CYCLES + 1)
        else $error("program time");
    a_block_cause: assert property ($rose(ctrl_rdata[BLOCKED_BIT]) |->
        $past(addr_wr) || $past(addr_wr, 2))
        else $error("blocked without start");
    a_ctrl_store: assert property (ctrl_wr |=> mode == $past(sfr_wdata[5:4])
        && ctrl_rdata[A8_BIT] == $past(sfr_wdata[A8_BIT]))
        else $error("control not stored");
    a_data_hold: assert property ($changed(data_rdata) |->
        $past(sfr_wr && sfr_sel == SEL_DATA) || $rose(done))
        else $error("data changed");
    a_lowv_when: assert property ($rose(ctrl_rdata[LOWV_BIT]) |-> wr_act)
        else $error("low supply flag while idle");
endmodule // eeprom_link_props

// File: testbench/testbench.sv
/*
 * Self-checking bench for the EEPROM controller and its CPU end.
 * Assumes the package and link interface of rtl/.
 */
`timescale 1ns/100ps
module testbench;
    import eeprom_pkg::*;
    localparam int OPC = 600;
    logic        clk, arst_n, vdd_low, busy;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [2:0]  awprot, arprot;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, lfsr, st;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  model [ARRAY_BYTES];
    int          err_count, n_tests;

    eeprom_sfr_if u_eeprom_sfr_if ();
    eeprom_ctrl #(.OP_CYCLES(OPC)) u_eeprom_ctrl (.clk, .arst_n,
        .sfr(u_eeprom_sfr_if.dev), .vdd_low, .busy);
    eeprom_cpu_end u_eeprom_cpu_end (.clk, .arst_n, .sfr(u_eeprom_sfr_if.cpu), .awaddr,
        .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    eeprom_link_props #(.OP_CYCLES(OPC)) u_eeprom_link_props (.clk, .arst_n,
        .sfr_wr(u_eeprom_sfr_if.sfr_wr), .sfr_sel(u_eeprom_sfr_if.sfr_sel),
        .sfr_wdata(u_eeprom_sfr_if.sfr_wdata), .ctrl_rdata(u_eeprom_sfr_if.ctrl_rdata),
        .data_rdata(u_eeprom_sfr_if.data_rdata), .irq_req(u_eeprom_sfr_if.irq_req),
        .done_irq_en(u_eeprom_sfr_if.done_irq_en),
        .global_irq_en(u_eeprom_sfr_if.global_irq_en));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [8:0] row_base(input logic [8:0] a);
        return {a[8:6], 6'h00};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // bready and rready stay high, so no answer is ever stalled
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        rs = bresp;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
    endtask

    task automatic cmd(input logic [1:0] s, input logic [7:0] b);
        wr(OFF_CMD, {22'h0, s, b}, r);
        check(r, RESP_OKAY);
    endtask

    task automatic wait_done();
        do rd(OFF_STATUS, st, r); while (st[DONE_BIT] !== 1'b1);
    endtask

    // the control write also clears all flags before the start
    task automatic go(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d, int nd);
        cmd(SEL_CTRL, {2'b00, m, 3'b000, a[8]});
        for (int j = nd; j > 0; j--) cmd(SEL_DATA, j > 1 ? ~d : d);
        cmd(SEL_ADDR, a[7:0]);
    endtask

    task automatic peek(input logic [8:0] a);
        go(MODE_BYTE, a, 8'h00, 0);
        wait_done();
        check(st[15:8], model[a]);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    // ****************
    // main sequence
    // ****************
    initial
    begin
        logic [8:0] a;
        logic [7:0] d;
        err_count = 0;
        n_tests = 0;
        lfsr = 32'h5A36;
        {arst_n, vdd_low, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        {awprot, arprot, wstrb, bready, rready} = {6'h0, 4'hF, 2'b11};
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFF_STATUS, st, r);
        check(st, 32'h0);
        rd(4'hC, st, r);
        check(st, 32'h0);
        check(r, RESP_SLV);
        lfsr = nxt(lfsr);
        d = lfsr[7:0];
        go(MODE_BLOCK, {1'b1, lfsr[15:8]}, d, 1);
        wait_done();
        check(st[15:0], {d, 1'b1, 1'b0, MODE_BLOCK, 4'h1});
        foreach (model[i]) model[i] = d;
        for (int k = 0; k < 4; k++)
        begin
            lfsr = nxt(lfsr);
            a = lfsr[8:0];
            if (k % 2 == 0) d = lfsr[16:9];
            go(MODE_ROW, a, d, 1 - k % 2);
            wait_done();
            check(st[15:8], d);
            for (int i = 0; i < ROW_BYTES; i++) model[row_base(a) + i] = d;
        end
        peek(row_base(a));
        peek(row_base(a) + 9'd63);
        peek(row_base(a) - 9'd1);
        for (int k = 0; k < 3; k++)
        begin
            lfsr = nxt(lfsr);
            a = lfsr[8:0];
            go(MODE_BYTE, a, lfsr[16:9], 2);
            wait_done();
            model[a] = lfsr[16:9];
            cmd(SEL_CTRL, {2'b00, MODE_ROW, 4'h0});
            cmd(SEL_DATA, ~model[a]);
            peek(a);
            peek(a);
        end
        vdd_low <= 1'b1;
        go(MODE_ROW, a, ~model[a], 1);
        repeat (2) rd(OFF_STATUS, st, r);
        check(st[7:0] & 8'h86, 32'h04);
        check(busy, 1'b0);
        vdd_low <= 1'b0;
        peek(a);
        a = 9'h1FF;
        go(MODE_ROW, a, d, 1);
        repeat (50) @(posedge clk);
        check(busy, 1'b1);
        vdd_low <= 1'b1;
        repeat (3) @(posedge clk);
        vdd_low <= 1'b0;
        wait_done();
        check(st[2:1], 2'b01);
        check(busy, 1'b0);
        wr(OFF_IRQ_EN, 32'h1, r);
        repeat (2) rd(OFF_STATUS, st, r);
        check(st[16], 1'b0);
        wr(OFF_IRQ_EN, 32'h3, r);
        repeat (2) rd(OFF_STATUS, st, r);
        check({st[16], st[7]}, 2'b11);
        cmd(SEL_CTRL, 8'h00);
        repeat (2) rd(OFF_STATUS, st, r);
        check(st[16], 1'b0);
        cmd(SEL_DATA, ~model[5]);
        repeat (2) @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        peek(9'h005);
        tally_and_finish();
    end
endmodule // testbench
